// >>> core/sssc_regs.vh
// register offsets, field positions and reset values of the switch status
// and sequencer configuration bank; definitions only
`ifndef SSSC_REGS_VH
`define SSSC_REGS_VH

`define SSSC_ADDR_SWITCH_FLAGS 7'h41
`define SSSC_ADDR_SEQ_SETUP 7'h54
`define SSSC_ADDR_COIL_SCALE 7'h55
`define SSSC_ADDR_STALL_READ 7'h56
`define SSSC_ADDR_DRV_FLAGS 7'h57
`define SSSC_ADDR_CHOP_DIV 7'h59
`define SSSC_ADDR_STALL_THR 7'h5B

`define SSSC_FLG_STOP_L 0
`define SSSC_FLG_STOP_R 1
`define SSSC_FLG_LATCH_L 2
`define SSSC_FLG_LATCH_R 3
`define SSSC_FLG_COND_L 4
`define SSSC_FLG_COND_R 5
`define SSSC_FLG_STALL 6

`define SSSC_SEQ_LEN_LSB 0
`define SSSC_SEQ_LEN_MSB 3
`define SSSC_SEQ_HALT 8
`define SSSC_SEQ_RST 9'h000
`define SSSC_LEN_MAX 4'hB
`define SSSC_TABLE_FULL 14'h2000

`define SSSC_RUN_CUR_LSB 0
`define SSSC_RUN_CUR_MSB 4
`define SSSC_RUN_DECAY 7
`define SSSC_SB_CUR_LSB 8
`define SSSC_SB_CUR_MSB 12
`define SSSC_SB_DECAY 15
`define SSSC_SCALE_RST 24'h000090
`define SSSC_SCALE_FULL 5'h10
`define SSSC_SCALE_SHIFT 4

`define SSSC_CHOP_RST 12'h280
`define SSSC_CHOP_MIN 12'h060

`endif

// >>> core/sssc_sw_side.v
// one stop-switch input: polarity, edge detect, position-latch ready flag
// assumes the switch pin is already synchronous to i_clk
module sssc_sw_side (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_pin,
  input wire i_pol_low,
  input wire i_latch_act_en,
  input wire i_latch_inact_en,
  input wire i_flag_clr,
  output wire o_active,
  output wire o_latch_hit,
  output reg o_ready_q
);
  reg prev_q;
  reg primed_q;
  wire rise;
  wire fall;

  assign o_active = i_pin ^ i_pol_low;
  // no edge until one sample is held: avoids a false latch after reset
  assign rise = primed_q & o_active & ~prev_q;
  assign fall = primed_q & ~o_active & prev_q;
  assign o_latch_hit = (rise & i_latch_act_en) | (fall & i_latch_inact_en);

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      prev_q <= 1'b0;
      primed_q <= 1'b0;
      o_ready_q <= 1'b0;
    end
    else if (i_ce)
    begin
      prev_q <= o_active;
      primed_q <= 1'b1;
      if (o_latch_hit)
        o_ready_q <= 1'b1;
      else if (i_flag_clr)
        o_ready_q <= 1'b0;
    end
  end
endmodule // sssc_sw_side

// >>> core/sssc_bank.v
// switch status and microstep sequencer configuration register bank
// assumes a simple synchronous register port and synchronous inputs;
// switch-mode bits arrive as inputs from the configuration register outside
`include "sssc_regs.vh"

// Summary of operation
// - bits 0,1 show live left/right switch state
// - bit 2 left latch ready, read clears
// - bit 3 right latch ready, read clears
// - bits 4,5 live stop-condition status
// - bit 6 stall stop flag, read clears
// - table length code selects entries per period
// - microstep resolution is quarter table length
// - bit 8 halts the sequencer
// - 0x56 reads latest driver stall value
// - 0x57 reads driver error, prewarning, stall
// - 0x59 write-only chopper divider, reset 640
// - chopper divider never held below 96
// - run current scales sine, 16 full, 0 off
// - standby current used after standstill delay
// - latch ramp position on enabled switch edge
module sssc_bank #(
  parameter SINE_W = 12,
  parameter POS_W = 32,
  parameter DLY_W = 24
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [6:0] i_addr,
  input wire [31:0] i_wdata,
  output reg [31:0] o_rdata,
  output reg o_rd_valid,
  input wire i_stop_l,
  input wire i_stop_r,
  input wire i_pol_stop_l,
  input wire i_pol_stop_r,
  input wire i_latch_l_act,
  input wire i_latch_l_inact,
  input wire i_latch_r_act,
  input wire i_latch_r_inact,
  input wire i_stop_cond_l,
  input wire i_stop_cond_r,
  input wire i_stall_halt_event,
  input wire [POS_W-1:0] i_ramp_pos,
  output reg [POS_W-1:0] o_latch_pos,
  output reg o_latch_strobe,
  input wire [2:0] i_drv_stall_value,
  input wire i_drv_error,
  input wire i_drv_otpw,
  input wire i_drv_stall,
  input wire i_standstill,
  input wire [DLY_W-1:0] i_stdby_delay,
  input wire signed [SINE_W-1:0] i_sine_a,
  input wire signed [SINE_W-1:0] i_sine_b,
  output reg signed [SINE_W-1:0] o_coil_a,
  output reg signed [SINE_W-1:0] o_coil_b,
  output reg o_coil_en,
  output reg o_blended_decay,
  output reg o_standby_active,
  output wire [3:0] o_table_len_sel,
  output wire [13:0] o_table_entries,
  output wire [11:0] o_ustep_res,
  output wire o_seq_halt,
  output wire [11:0] o_chop_div,
  output wire [2:0] o_stall_thresh
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // codes above full stepping are held at full stepping
  function [3:0] len_clamp;
    input [3:0] code;
    begin
      len_clamp = (code > `SSSC_LEN_MAX) ? `SSSC_LEN_MAX : code;
    end
  endfunction

  // n/16 of the sine entry; codes above 16 act as full scale
  function signed [SINE_W-1:0] scale_sine;
    input signed [SINE_W-1:0] s;
    input [4:0] n;
    reg [4:0] nc;
    reg signed [SINE_W+5:0] prod;
    begin
      nc = (n > `SSSC_SCALE_FULL) ? `SSSC_SCALE_FULL : n;
      prod = s * $signed({1'b0, nc});
      scale_sine = prod[SINE_W+`SSSC_SCALE_SHIFT-1:`SSSC_SCALE_SHIFT];
    end
  endfunction

  // ------------------------------------------------------------
  // switch inputs
  // ------------------------------------------------------------
  wire rd_flags = i_rd_en & (i_addr == `SSSC_ADDR_SWITCH_FLAGS);
  wire act_l;
  wire act_r;
  wire hit_l;
  wire hit_r;
  wire rdy_l;
  wire rdy_r;
  reg stall_flag_q;

  sssc_sw_side u_left (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_pin(i_stop_l),
    .i_pol_low(i_pol_stop_l),
    .i_latch_act_en(i_latch_l_act),
    .i_latch_inact_en(i_latch_l_inact),
    .i_flag_clr(rd_flags),
    .o_active(act_l),
    .o_latch_hit(hit_l),
    .o_ready_q(rdy_l)
  );

  sssc_sw_side u_right (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_pin(i_stop_r),
    .i_pol_low(i_pol_stop_r),
    .i_latch_act_en(i_latch_r_act),
    .i_latch_inact_en(i_latch_r_inact),
    .i_flag_clr(rd_flags),
    .o_active(act_r),
    .o_latch_hit(hit_r),
    .o_ready_q(rdy_r)
  );

  // a hit on either side, or on both in one cycle, latches the same ramp position; one latch register only
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_latch_pos <= {POS_W{1'b0}};
      o_latch_strobe <= 1'b0;
      stall_flag_q <= 1'b0;
    end
    else if (i_ce)
    begin
      o_latch_strobe <= hit_l | hit_r;
      if (hit_l | hit_r)
        o_latch_pos <= i_ramp_pos;
      if (i_stall_halt_event)
        stall_flag_q <= 1'b1;
      else if (rd_flags)
        stall_flag_q <= 1'b0;
    end
  end

  wire [6:0] flags_word;
  assign flags_word[`SSSC_FLG_STOP_L] = act_l;
  assign flags_word[`SSSC_FLG_STOP_R] = act_r;
  assign flags_word[`SSSC_FLG_LATCH_L] = rdy_l;
  assign flags_word[`SSSC_FLG_LATCH_R] = rdy_r;
  assign flags_word[`SSSC_FLG_COND_L] = i_stop_cond_l;
  assign flags_word[`SSSC_FLG_COND_R] = i_stop_cond_r;
  assign flags_word[`SSSC_FLG_STALL] = stall_flag_q;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  reg [8:0] seq_setup_q;
  reg [23:0] coil_scale_q;
  reg [11:0] chop_div_q;
  reg [2:0] stall_thr_q;

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      seq_setup_q <= `SSSC_SEQ_RST;
      coil_scale_q <= `SSSC_SCALE_RST;
      chop_div_q <= `SSSC_CHOP_RST;
      stall_thr_q <= 3'h0;
    end
    else if (i_ce & i_wr_en)
    begin
      case (i_addr)
        `SSSC_ADDR_SEQ_SETUP: seq_setup_q <= i_wdata[8:0];
        `SSSC_ADDR_COIL_SCALE: coil_scale_q <= i_wdata[23:0];
        `SSSC_ADDR_CHOP_DIV:
        begin
          // too-small requests are raised to the floor, not ignored
          if (i_wdata[11:0] < `SSSC_CHOP_MIN)
            chop_div_q <= `SSSC_CHOP_MIN;
          else
            chop_div_q <= i_wdata[11:0];
        end
        `SSSC_ADDR_STALL_THR: stall_thr_q <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  assign o_table_len_sel = len_clamp(seq_setup_q[`SSSC_SEQ_LEN_MSB:`SSSC_SEQ_LEN_LSB]);
  assign o_table_entries = `SSSC_TABLE_FULL >> o_table_len_sel;
  assign o_ustep_res = o_table_entries[13:2];
  assign o_seq_halt = seq_setup_q[`SSSC_SEQ_HALT];
  assign o_chop_div = chop_div_q;
  assign o_stall_thresh = stall_thr_q;

  // ------------------------------------------------------------
  // coil current scaling with standby switch-over
  // ------------------------------------------------------------
  reg [DLY_W-1:0] still_cnt_q;
  wire [4:0] run_current_scale = coil_scale_q[`SSSC_RUN_CUR_MSB:`SSSC_RUN_CUR_LSB];
  wire [4:0] standby_current_scale = coil_scale_q[`SSSC_SB_CUR_MSB:`SSSC_SB_CUR_LSB];
  wire run_blended_decay = coil_scale_q[`SSSC_RUN_DECAY];
  wire standby_blended_decay = coil_scale_q[`SSSC_SB_DECAY];
  wire still_done = (still_cnt_q >= i_stdby_delay);
  wire [4:0] cur_scale = still_done ? standby_current_scale : run_current_scale;

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      still_cnt_q <= {DLY_W{1'b0}};
      o_standby_active <= 1'b0;
      o_coil_a <= {SINE_W{1'b0}};
      o_coil_b <= {SINE_W{1'b0}};
      o_coil_en <= 1'b0;
      o_blended_decay <= 1'b0;
    end
    else if (i_ce)
    begin
      // any motion restarts the standstill wait
      if (!i_standstill)
        still_cnt_q <= {DLY_W{1'b0}};
      else if (!still_done)
        still_cnt_q <= still_cnt_q + {{(DLY_W-1){1'b0}}, 1'b1};
      o_standby_active <= i_standstill & still_done;
      o_coil_a <= scale_sine(i_sine_a, i_standstill & still_done ? standby_current_scale
                                                                  : run_current_scale);
      o_coil_b <= scale_sine(i_sine_b, (i_standstill & still_done) ? cur_scale
                                                                    : run_current_scale);
      o_coil_en <= (i_standstill & still_done) ? (standby_current_scale != 5'h00)
                                               : (run_current_scale != 5'h00);
      o_blended_decay <= (i_standstill & still_done) ? standby_blended_decay
                                                     : run_blended_decay;
    end
  end

  // ------------------------------------------------------------
  // read port: write-only and unmapped offsets read zero
  // ------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= 32'h00000000;
      o_rd_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en)
      begin
        case (i_addr)
          `SSSC_ADDR_SWITCH_FLAGS: o_rdata <= {25'h0, flags_word};
          `SSSC_ADDR_SEQ_SETUP: o_rdata <= {23'h0, seq_setup_q};
          `SSSC_ADDR_STALL_READ: o_rdata <= {29'h0, i_drv_stall_value};
          `SSSC_ADDR_DRV_FLAGS:
            o_rdata <= {29'h0, i_drv_stall, i_drv_otpw, i_drv_error};
          default: o_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // sssc_bank

// >>> verif/sssc_drv_model.sv
// power-stage driver stand-in: stall reading and status flags
// reports what the bench sets one clock late, like a serial readback
module sssc_drv_model (
  input wire i_clk,
  input wire [2:0] i_sv,
  input wire [2:0] i_st,
  output logic [2:0] o_sv = 3'h0,
  output logic o_err = 1'h0,
  output logic o_otpw = 1'h0,
  output logic o_stall = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_clk)
  begin
    o_sv <= i_sv;
    {o_stall, o_otpw, o_err} <= i_st;
  end
endmodule // sssc_drv_model

// >>> verif/sssc_bank_assertions.sv
// checker on the register port and configuration outputs of sssc_bank
// sees only the bank's ports; bound in after the module
module sssc_bank_chk (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [6:0] i_addr,
  input wire [31:0] i_wdata,
  input wire [31:0] o_rdata,
  input wire i_stall_halt_event,
  input wire [2:0] i_drv_stall_value,
  input wire [13:0] o_table_entries,
  input wire [11:0] o_ustep_res,
  input wire o_seq_halt,
  input wire [11:0] o_chop_div,
  input wire [2:0] o_stall_thresh
);
  timeunit 1ns;
  timeprecision 1ps;
  wire rd = i_ce && i_rd_en;
  wire wr = i_ce && i_wr_en;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  chk_stall_read: assert property (
    rd && i_addr == 7'h56 |=> o_rdata == {29'h0, $past(i_drv_stall_value)})
    else $error("stall reading wrong");
  chk_stall_flag: assert property (
    i_stall_halt_event ##1 (rd && i_addr == 7'h41) |=> o_rdata[6])
    else $error("stall flag lost");
  chk_chop_floor: assert property (o_chop_div >= 12'h060)
    else $error("divider below floor");
  chk_chop_write: assert property (
    wr && i_addr == 7'h59 |=> o_chop_div == ($past(i_wdata[11:0]) < 12'h060 ?
    12'h060 : $past(i_wdata[11:0])))
    else $error("divider write wrong");
  chk_table_len: assert property (
    wr && i_addr == 7'h54 |=> o_table_entries == 14'h2000 >>
    ($past(i_wdata[3:0]) > 4'hB ? 4'hB : $past(i_wdata[3:0])))
    else $error("table length wrong");
  chk_quarter_res: assert property (o_ustep_res == o_table_entries[13:2])
    else $error("resolution wrong");
  chk_halt_bit: assert property (
    wr && i_addr == 7'h54 |=> o_seq_halt == $past(i_wdata[8]))
    else $error("halt bit wrong");
  chk_thresh_fwd: assert property (
    wr && i_addr == 7'h5B |=> o_stall_thresh == $past(i_wdata[2:0]))
    else $error("threshold wrong");
  chk_ce_freeze: assert property (
    !i_ce |=> $stable(o_chop_div) && $stable(o_seq_halt) && $stable(o_stall_thresh))
    else $error("configuration moved while clock enable low");
  cov_clamp: cover property (wr && i_addr == 7'h59 && i_wdata[11:0] < 12'h060);
  cov_stall: cover property (i_stall_halt_event ##1 (rd && i_addr == 7'h41));
  cov_halt: cover property (o_seq_halt && o_table_entries == 14'h0004);
endmodule // sssc_bank_chk
bind sssc_bank sssc_bank_chk u_chk (.*);

// >>> verif/sssc_bank_tb_top.sv
// self-checking bench for sssc_bank with a driver stand-in
// inputs change on the falling edge of a 125 MHz clock
module sssc_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_srst = 1'h1, i_ce = 1'h1, i_wr_en = 1'h0, i_rd_en = 1'h0;
  logic i_stop_l = 1'h0, i_stop_r = 1'h0, i_pol_stop_l = 1'h0, i_pol_stop_r = 1'h1;
  logic i_latch_l_act = 1'h0, i_latch_l_inact = 1'h0, i_latch_r_act = 1'h0;
  logic i_latch_r_inact = 1'h0, i_stop_cond_l = 1'h0, i_stop_cond_r = 1'h0;
  logic i_stall_halt_event = 1'h0, i_standstill = 1'h0, o_rd_valid, o_latch_strobe;
  logic i_drv_error, i_drv_otpw, i_drv_stall, o_coil_en, o_blended_decay;
  logic o_standby_active, o_seq_halt;
  logic [6:0] i_addr = 7'h00;
  logic [31:0] i_wdata = 32'h0, i_ramp_pos = 32'h0, o_rdata, o_latch_pos;
  logic [2:0] i_drv_stall_value, o_stall_thresh, sv = 3'h0, st = 3'h0;
  logic [23:0] i_stdby_delay = 24'h0;
  logic signed [11:0] i_sine_a = 12'sh3E8, i_sine_b = -12'sh320, o_coil_a, o_coil_b;
  logic [3:0] o_table_len_sel;
  logic [13:0] o_table_entries;
  logic [11:0] o_ustep_res, o_chop_div;
  int bad_count = 0, check_count = 0;
  always #4 i_clk = ~i_clk;
  sssc_bank u_dut (.*);
  sssc_drv_model u_drv (.i_clk, .i_sv(sv), .i_st(st), .o_sv(i_drv_stall_value),
    .o_err(i_drv_error), .o_otpw(i_drv_otpw), .o_stall(i_drv_stall));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // extra idle cycle so back-to-back calls never retoggle a strobe
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'h1;
    @(negedge i_clk) i_wr_en = 1'h0;
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    i_addr = a;
    i_rd_en = 1'h1;
    @(negedge i_clk) i_rd_en = 1'h0;
    cmp(o_rd_valid, 32'h1);
    cmp(o_rdata, e);
    @(negedge i_clk);
  endtask
  task automatic waitfor(ref logic s);
    int n = 0;
    while (s !== 1'h1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    if (s !== 1'h1)
    begin
      bad_count++;
      summarize();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_switch;
    i_latch_l_act = 1'h1;
    i_latch_r_inact = 1'h1;
    i_ramp_pos = 32'hA5C3_0F12;
    @(negedge i_clk);
    i_stop_l = 1'h1;
    waitfor(o_latch_strobe);
    cmp(o_latch_pos, 32'hA5C3_0F12);
    i_stop_cond_l = 1'h1;
    rd(7'h41, 32'h17);
    rd(7'h41, 32'h13);
    i_stop_r = 1'h1;
    i_stop_cond_r = 1'h1;
    waitfor(o_latch_strobe);
    rd(7'h41, 32'h39);
    rd(7'h41, 32'h31);
  endtask
  task automatic t_stall;
    sv = 3'h5;
    st = 3'h5;
    @(negedge i_clk);
    rd(7'h56, 32'h5);
    rd(7'h57, 32'h5);
    st = 3'h2;
    @(negedge i_clk);
    rd(7'h57, 32'h2);
    i_stall_halt_event = 1'h1;
    @(negedge i_clk) i_stall_halt_event = 1'h0;
    rd(7'h41, 32'h71);
    i_stall_halt_event = 1'h1;
    fork
      rd(7'h41, 32'h31);
      @(negedge i_clk) i_stall_halt_event = 1'h0;
    join
    rd(7'h41, 32'h71);
  endtask
  task automatic t_chop;
    logic [11:0] v [5] = '{12'h032, 12'h05F, 12'h060, 12'hFFF, 12'h000};
    foreach (v[i])
    begin
      wr(7'h59, {20'h0, v[i]});
      cmp(o_chop_div, v[i] < 12'h060 ? 12'h060 : v[i]);
    end
    rd(7'h59, 32'h0);
    wr(7'h5B, 32'h6);
    cmp(o_stall_thresh, 32'h6);
    wr(7'h56, 32'h7);
    rd(7'h56, 32'h5);
    rd(7'h58, 32'h0);
  endtask
  task automatic t_seq;
    int s;
    for (int c = 0; c < 16; c++)
    begin
      wr(7'h54, {23'h0, c[0], 4'h0, c[3:0]});
      s = c > 11 ? 11 : c;
      cmp(o_table_entries, 14'h2000 >> s);
      cmp(o_table_len_sel, s);
      cmp(o_ustep_res, 12'h800 >> s);
      cmp(o_seq_halt, c[0]);
      if (c < 12)
        rd(7'h54, {23'h0, c[0], 4'h0, c[3:0]});
    end
  endtask
  // clock enable low: writes must not land anywhere
  task automatic t_hold;
    i_ce = 1'h0;
    wr(7'h59, 32'h123);
    wr(7'h54, 32'h100);
    wr(7'h5B, 32'h1);
    cmp(o_chop_div, 32'h60);
    cmp(o_seq_halt, 32'h0);
    cmp(o_stall_thresh, 32'h6);
    i_ce = 1'h1;
    @(negedge i_clk);
    cmp(o_chop_div, 32'h60);
  endtask
  task automatic t_scale;
    i_stdby_delay = 24'h3;
    i_sine_a = 12'sh7D0;
    wr(7'h55, 32'h8408);
    cmp(o_coil_a, 32'h3E8);
    cmp(o_coil_b, 32'hFFFFFE70);
    i_standstill = 1'h1;
    @(negedge i_clk);
    cmp(o_standby_active, 32'h0);
    waitfor(o_standby_active);
    @(negedge i_clk);
    cmp(o_coil_a, 32'h1F4);
    cmp(o_blended_decay, 32'h1);
    i_standstill = 1'h0;
    wr(7'h55, 32'h0);
    cmp(o_coil_en, 32'h0);
  endtask

  initial
  begin
    repeat (4) @(negedge i_clk);
    i_srst = 1'h0;
    @(negedge i_clk);
    cmp(o_chop_div, 32'h280);
    cmp(o_stall_thresh, 32'h0);
    cmp(o_coil_b, 32'hFFFFFCE0);
    t_switch;
    t_stall;
    t_chop;
    t_hold;
    t_seq;
    t_scale;
    summarize;
  end
endmodule // sssc_bank_tb_top
